/* design/dci_pkg.sv */
package dci_pkg;

    // Command bytes
    localparam logic [7:0] CMD_REV_RD   = 8'h00;
    localparam logic [7:0] CMD_CNTR_WR  = 8'h01;
    localparam logic [7:0] CMD_STAT_RD  = 8'h02;
    localparam logic [7:0] CMD_CNTR_RD  = 8'h03;
    localparam logic [7:0] CMD_CTL_WR   = 8'h04;
    localparam logic [7:0] CMD_CTL_RD   = 8'h05;
    localparam logic [7:0] CMD_PC_WR    = 8'h06;
    localparam logic [7:0] CMD_PC_RD    = 8'h07;
    localparam logic [7:0] CMD_REG_WR   = 8'h08;
    localparam logic [7:0] CMD_REG_RD   = 8'h09;
    localparam logic [7:0] CMD_PMEM_WR  = 8'h0a;
    localparam logic [7:0] CMD_PMEM_RD  = 8'h0b;
    localparam logic [7:0] CMD_DMEM_WR  = 8'h0c;
    localparam logic [7:0] CMD_STEP     = 8'h10;
    localparam logic [7:0] CMD_STUFF    = 8'h11;
    localparam logic [7:0] CMD_EXEC     = 8'h12;

    // Control register layout and reset values
    localparam int          HALTED_FOR_DEBUG_FLAG_BIT  = 7;
    localparam logic [7:0]  CTL_RESET    = 8'h00;
    localparam logic [15:0] CNTR_RESET   = 16'h0000;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [15:0] ALL_ONES16   = 16'hffff;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    // Revision value is arbitrary
    localparam logic [15:0] DEF_REVISION = 16'h0100;

    // Character framing: start, eight data, stop
    localparam int          BYTE_W       = 8;
    localparam int          BITCNT_W     = 10;
    localparam logic [3:0]  START_IDX    = 4'h0;
    localparam logic [3:0]  STOP_IDX     = 4'h9;
    localparam logic [3:0]  TX_LAST_IDX  = 4'h9;
    localparam logic [9:0]  TX_IDLE_SHIFT = 10'h3ff;

    // Reply buffer
    localparam int          FIFO_DEPTH   = 16;

    // Command decoder states
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_ARG_HI  = 5'b00010,
        ST_ARG_LO  = 5'b00100,
        ST_PUSH_HI = 5'b01000,
        ST_PUSH_LO = 5'b10000
    } dci_state_t;

endpackage : dci_pkg

/* design/dci_stream_if.sv */
`timescale 1ns/1ps
interface dci_stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dci_stream_if

/* design/dci_fifo.sv */
`timescale 1ns/1ps
module dci_fifo
    import dci_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input wire logic   sys_clk_i,
    input wire logic   sys_rst_i,
    dci_stream_if.snk  in_s,
    dci_stream_if.src  out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   cnt_reg;
    logic          out_valid_reg;
    logic [W-1:0]  out_data_reg;

    // Handshake decode
    wire full_w     = (cnt_reg == (AW+1)'(DEPTH));
    wire push_w     = in_s.valid & ~full_w;
    wire out_take_w = out_valid_reg & out_s.ready;
    wire pop_mem_w  = (~out_valid_reg | out_take_w) & (cnt_reg != '0);

    assign in_s.ready  = ~full_w;
    assign out_s.valid = out_valid_reg;
    assign out_s.data  = out_data_reg;

    // Storage array
    always_ff @(posedge sys_clk_i) begin
        if (push_w) begin
            mem[wr_ptr_reg] <= in_s.data;
        end
    end

    // Pointers, fill count and registered head
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            cnt_reg       <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop_mem_w) begin
                rd_ptr_reg   <= rd_ptr_reg + 1'b1;
                out_data_reg <= mem[rd_ptr_reg];
            end
            out_valid_reg <= pop_mem_w | (out_valid_reg & ~out_take_w);
            cnt_reg       <= cnt_reg + (AW+1)'(push_w) - (AW+1)'(pop_mem_w);
        end
    end
endmodule : dci_fifo

/* design/dci_top.sv */
// Function
// - Outside debug halt only revision, status, control write and read take effect.
// - While halted every defined command is available, less the read-lock limits; only 00h to 07h are decoded, the others are ignored.
// - Read-lock disables PC, register read, memory writes and reads, step, stuff, execute.
// - Read-lock limits register writes to flash control, mass erase value only.
// - Command 00h replies two revision bytes, major then minor.
// - Command 01h takes 16-bit counter, high first; loaded only when halted.
// - Command 02h replies one status byte.
// - Command 03h replies inverted counter high first, or all ones if running.
// - Command 04h takes one control byte; read-lock forbids clearing bit 7.
// - Command 05h replies the control register byte.
// - Command 06h takes 16-bit PC high first; loaded only halted and unlocked.
// - Command 07h replies PC high first, or all ones if running or locked.
// - Characters are start bit, eight data bits LSB first, one stop bit.
`timescale 1ns/1ps
module dci_top
    import dci_pkg::*;
#(
    parameter logic [15:0] REVISION = DEF_REVISION
) (
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                debug_serial_pin_i,
    output wire logic                debug_serial_pin_o,
    output wire logic                debug_serial_pin_oe_n_o,
    input  wire logic [BITCNT_W-1:0] bit_cycles_i,
    input  wire logic                read_lock_option_i,
    input  wire logic                debug_enter_i,
    input  wire logic [7:0]          debugger_status_reg_i,
    input  wire logic [15:0]         pc_i,
    output wire logic                pc_wr_o,
    output wire logic [15:0]         pc_wdata_o,
    output wire logic                ctl_wr_o,
    output wire logic [7:0]          debugger_control_reg_o,
    output wire logic [15:0]         debug_down_counter_o,
    output wire logic                halted_for_debug_flag_o,
    output wire logic                reg_write_flash_only_o,
    output wire logic                frame_error_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Command gating functions

    // Commands shut off by the read-lock option
    function automatic logic cmd_locked_out(input logic [7:0] cmd);
        case (cmd)
            CMD_PC_WR, CMD_PC_RD, CMD_REG_RD, CMD_PMEM_WR, CMD_PMEM_RD,
            CMD_DMEM_WR, CMD_STEP, CMD_STUFF, CMD_EXEC: cmd_locked_out = 1'b1;
            default: cmd_locked_out = 1'b0;
        endcase
    endfunction : cmd_locked_out

    // Whether a command may act in the present mode
    function automatic logic cmd_enabled(input logic [7:0] cmd, input logic halted, input logic lock);
        if (halted) begin
            cmd_enabled = ~(lock & cmd_locked_out(cmd));
        end else begin
            cmd_enabled = (cmd == CMD_REV_RD) | (cmd == CMD_STAT_RD) |
                          (cmd == CMD_CTL_WR) | (cmd == CMD_CTL_RD);
        end
    endfunction : cmd_enabled

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    dci_state_t          st_reg;
    dci_state_t          st_next;
    logic [7:0]          cmd_reg;
    logic [7:0]          arg_hi_reg;
    logic [15:0]         reply_reg;
    logic [7:0]          ctl_reg;
    logic [15:0]         cnt_reg;
    logic                pc_wr_reg;
    logic [15:0]         pc_wdata_reg;
    logic                ctl_wr_reg;

    logic                rx_busy_reg;
    logic [3:0]          rx_idx_reg;
    logic [BITCNT_W-1:0] rx_cyc_reg;
    logic [7:0]          rx_shift_reg;
    logic                rx_valid_reg;
    logic                rx_ferr_reg;

    logic                tx_busy_reg;
    logic [3:0]          tx_idx_reg;
    logic [BITCNT_W-1:0] tx_cyc_reg;
    logic [9:0]          tx_shift_reg;
    logic                pin_oe_n_reg;

    dci_stream_if #(.W(BYTE_W)) push_s ();
    dci_stream_if #(.W(BYTE_W)) pop_s ();

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    wire halted_w  = ctl_reg[HALTED_FOR_DEBUG_FLAG_BIT];
    wire lock_w    = read_lock_option_i;
    wire rx_byte_w = rx_valid_reg;
    wire cmd_in_w  = rx_byte_w & (st_reg == ST_IDLE);
    wire arg_end_w = rx_byte_w & (st_reg == ST_ARG_LO);
    wire en_in_w   = cmd_enabled(rx_shift_reg, halted_w, lock_w);
    wire en_cur_w  = cmd_enabled(cmd_reg, halted_w, lock_w);

    // Argument completion strobes
    wire cnt_load_w = arg_end_w & (cmd_reg == CMD_CNTR_WR) & en_cur_w;
    wire pc_load_w  = arg_end_w & (cmd_reg == CMD_PC_WR) & en_cur_w;
    wire ctl_load_w = arg_end_w & (cmd_reg == CMD_CTL_WR);

    // Bit 7 is sticky under read-lock
    wire [7:0] ctl_wval_w = lock_w ? (rx_shift_reg | (ctl_reg & 8'h80)) : rx_shift_reg;

    // Register writes reach flash control only while halted and locked
    assign reg_write_flash_only_o = halted_w & lock_w;

    ////////////////////////////////////////////////////////////////////////////
    // Reply word selection for read commands

    wire [15:0] rev_word_w  = REVISION;
    wire [15:0] stat_word_w = {BYTE_ZERO, debugger_status_reg_i};
    wire [15:0] cntr_word_w = halted_w ? ~cnt_reg : ALL_ONES16;
    wire [15:0] ctl_word_w  = {BYTE_ZERO, ctl_reg};
    wire [15:0] pc_word_w   = en_in_w ? pc_i : ALL_ONES16;

    ////////////////////////////////////////////////////////////////////////////
    // Decoder next state

    always_comb begin
        st_next = st_reg;
        if (rx_ferr_reg) begin
            st_next = ST_IDLE;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (rx_byte_w) begin
                        case (rx_shift_reg)
                            CMD_REV_RD, CMD_CNTR_RD, CMD_PC_RD: st_next = ST_PUSH_HI;
                            CMD_STAT_RD, CMD_CTL_RD:            st_next = ST_PUSH_LO;
                            CMD_CNTR_WR, CMD_PC_WR:             st_next = ST_ARG_HI;
                            CMD_CTL_WR:                         st_next = ST_ARG_LO;
                            default:                            st_next = ST_IDLE;
                        endcase
                    end
                end
                ST_ARG_HI:  st_next = rx_byte_w ? ST_ARG_LO : ST_ARG_HI;
                ST_ARG_LO:  st_next = rx_byte_w ? ST_IDLE : ST_ARG_LO;
                ST_PUSH_HI: st_next = push_s.ready ? ST_PUSH_LO : ST_PUSH_HI;
                ST_PUSH_LO: st_next = push_s.ready ? ST_IDLE : ST_PUSH_LO;
                default:    st_next = ST_IDLE;
            endcase
        end
    end

    // Replies enter the buffer high byte first
    assign push_s.valid = (st_reg == ST_PUSH_HI) | (st_reg == ST_PUSH_LO);
    assign push_s.data  = (st_reg == ST_PUSH_HI) ? reply_reg[15:8] : reply_reg[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Decoder registers

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st_reg     <= ST_IDLE;
            cmd_reg    <= BYTE_ZERO;
            arg_hi_reg <= BYTE_ZERO;
            reply_reg  <= ALL_ONES16;
        end else begin
            st_reg <= st_next;
            if (cmd_in_w) begin
                cmd_reg <= rx_shift_reg;
                case (rx_shift_reg)
                    CMD_REV_RD:  reply_reg <= rev_word_w;
                    CMD_STAT_RD: reply_reg <= stat_word_w;
                    CMD_CNTR_RD: reply_reg <= cntr_word_w;
                    CMD_CTL_RD:  reply_reg <= ctl_word_w;
                    CMD_PC_RD:   reply_reg <= pc_word_w;
                    default:     reply_reg <= reply_reg;
                endcase
            end
            if (rx_byte_w & (st_reg == ST_ARG_HI)) begin
                arg_hi_reg <= rx_shift_reg;
            end
        end
    end

    // Debug state registers; a debug entry event wins over a write clearing bit 7
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ctl_reg      <= CTL_RESET;
            cnt_reg      <= CNTR_RESET;
            pc_wr_reg    <= 1'b0;
            pc_wdata_reg <= PC_RESET;
            ctl_wr_reg   <= 1'b0;
        end else begin
            pc_wr_reg  <= pc_load_w;
            ctl_wr_reg <= ctl_load_w;
            if (ctl_load_w) begin
                ctl_reg <= ctl_wval_w | (debug_enter_i ? 8'h80 : 8'h00);
            end else if (debug_enter_i) begin
                ctl_reg[HALTED_FOR_DEBUG_FLAG_BIT] <= 1'b1;
            end
            if (cnt_load_w) begin
                cnt_reg <= {arg_hi_reg, rx_shift_reg};
            end
            if (pc_load_w) begin
                pc_wdata_reg <= {arg_hi_reg, rx_shift_reg};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver: start, eight data LSB first, stop; own transmission is not heard

    wire rx_start_w = ~rx_busy_reg & ~tx_busy_reg & ~debug_serial_pin_i;
    wire rx_tick_w  = rx_busy_reg & (rx_cyc_reg == '0);

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rx_busy_reg  <= 1'b0;
            rx_idx_reg   <= START_IDX;
            rx_cyc_reg   <= '0;
            rx_shift_reg <= BYTE_ZERO;
            rx_valid_reg <= 1'b0;
            rx_ferr_reg  <= 1'b0;
        end else begin
            rx_valid_reg <= 1'b0;
            rx_ferr_reg  <= 1'b0;
            if (rx_start_w) begin
                rx_busy_reg <= 1'b1;
                rx_idx_reg  <= START_IDX;
                rx_cyc_reg  <= bit_cycles_i >> 1;
            end else if (rx_tick_w) begin
                rx_cyc_reg <= bit_cycles_i - 1'b1;
                rx_idx_reg <= rx_idx_reg + 1'b1;
                if (rx_idx_reg == START_IDX) begin
                    rx_busy_reg <= ~debug_serial_pin_i; // Glitch if line is high again
                end else if (rx_idx_reg == STOP_IDX) begin
                    rx_busy_reg  <= 1'b0;
                    rx_valid_reg <= debug_serial_pin_i;
                    rx_ferr_reg  <= ~debug_serial_pin_i; // Stop bit low aborts the command
                end else begin
                    rx_shift_reg <= {debug_serial_pin_i, rx_shift_reg[7:1]};
                end
            end else if (rx_busy_reg) begin
                rx_cyc_reg <= rx_cyc_reg - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reply buffer

    dci_fifo #(
        .W     (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_reply_fifo (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .in_s      (push_s),
        .out_s     (pop_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter: waits for the receiver to fall idle, drives low bits only

    wire tx_load_w = pop_s.valid & ~tx_busy_reg & ~rx_busy_reg;
    wire tx_tick_w = tx_busy_reg & (tx_cyc_reg == '0);
    assign pop_s.ready = ~tx_busy_reg & ~rx_busy_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tx_busy_reg  <= 1'b0;
            tx_idx_reg   <= START_IDX;
            tx_cyc_reg   <= '0;
            tx_shift_reg <= TX_IDLE_SHIFT;
            pin_oe_n_reg <= 1'b1;
        end else begin
            if (tx_load_w) begin
                tx_busy_reg  <= 1'b1;
                tx_idx_reg   <= START_IDX;
                tx_cyc_reg   <= bit_cycles_i - 1'b1;
                tx_shift_reg <= {1'b1, pop_s.data, 1'b0};
                pin_oe_n_reg <= 1'b0;
            end else if (tx_tick_w) begin
                tx_cyc_reg   <= bit_cycles_i - 1'b1;
                tx_idx_reg   <= tx_idx_reg + 1'b1;
                tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                pin_oe_n_reg <= tx_shift_reg[1] | (tx_idx_reg == TX_LAST_IDX);
                tx_busy_reg  <= (tx_idx_reg != TX_LAST_IDX);
            end else if (tx_busy_reg) begin
                tx_cyc_reg <= tx_cyc_reg - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign debug_serial_pin_o      = 1'b0;
    assign debug_serial_pin_oe_n_o = pin_oe_n_reg;
    assign pc_wr_o                 = pc_wr_reg;
    assign pc_wdata_o              = pc_wdata_reg;
    assign ctl_wr_o                = ctl_wr_reg;
    assign debugger_control_reg_o  = ctl_reg;
    assign debug_down_counter_o    = cnt_reg;
    assign halted_for_debug_flag_o = halted_w;
    assign frame_error_o           = rx_ferr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_cntr_hold_run: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $changed(cnt_reg) |-> $past(halted_w) && $past(arg_end_w))
        else $error("Counter changed outside a halted counter write");

    a_cntr_read_val: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cmd_in_w && rx_shift_reg == CMD_CNTR_RD) |=>
        reply_reg == ($past(halted_w) ? ~$past(cnt_reg) : 16'hffff))
        else $error("Counter reply is wrong");

    a_pc_write_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        pc_wr_o |-> $past(halted_w) && !$past(lock_w))
        else $error("PC written while running or locked");

    a_pc_read_ones: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cmd_in_w && rx_shift_reg == CMD_PC_RD && (!halted_w || lock_w)) |=> reply_reg == 16'hffff)
        else $error("PC reply not all ones when withheld");

    a_rev_reply: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cmd_in_w && rx_shift_reg == CMD_REV_RD) |=> reply_reg == REVISION && st_reg == ST_PUSH_HI)
        else $error("Revision reply is wrong");

    a_stat_reply: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cmd_in_w && rx_shift_reg == CMD_STAT_RD) |=>
        reply_reg[7:0] == $past(debugger_status_reg_i) && st_reg == ST_PUSH_LO)
        else $error("Status reply is wrong");

    a_ctl_reply: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cmd_in_w && rx_shift_reg == CMD_CTL_RD) |=> reply_reg[7:0] == $past(ctl_reg))
        else $error("Control reply is wrong");

    a_lock_sticky: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ($past(lock_w) && $past(ctl_reg[HALTED_FOR_DEBUG_FLAG_BIT])) |-> ctl_reg[HALTED_FOR_DEBUG_FLAG_BIT])
        else $error("Debug mode bit cleared under read-lock");

    a_reserved_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (cmd_in_w && (rx_shift_reg == 8'h0f || rx_shift_reg > CMD_EXEC)) |=> (st_reg == ST_IDLE && !push_s.valid)[*2])
        else $error("Reserved command produced activity");

    a_tx_start_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        tx_load_w |=> !debug_serial_pin_oe_n_o && tx_busy_reg)
        else $error("Start bit not driven low");

endmodule : dci_top

/* verification/dci_host_model.sv */
`timescale 1ns/1ps
module dci_host_model #(
    parameter int BIT_CYC = 8
) (
    input  wire logic sys_clk_i,
    input  wire logic line_i,
    output logic      host_line_o
);
    ////////////////////////////////////////////////////////////
    // Released line idles high through the pull-up
    initial host_line_o = 1'b1;

    // One character: lead idle, start, eight data LSB first, stop
    task automatic send_byte(input logic [7:0] b);
        send_frame(b, 1'b1);
    endtask : send_byte

    // Chosen stop level; every bit, stop too, stands a full bit time, then the line is released
    task automatic send_frame(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        repeat (BIT_CYC / 2) @(posedge sys_clk_i);
        for (int i = 0; i < 10; i++) begin
            host_line_o <= frame[i];
            repeat (BIT_CYC) @(posedge sys_clk_i);
        end
        host_line_o <= 1'b1;
    endtask : send_frame

    // Waits for a start bit under a bound, samples mid-bit
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        ok = 1'b0;
        while (line_i !== 1'b0 && n < 400) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 400) return;
        repeat (BIT_CYC / 2) @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge sys_clk_i);
            b[i] = line_i;
        end
        repeat (BIT_CYC) @(posedge sys_clk_i);
        ok = (line_i === 1'b1);
    endtask : recv_byte

    // Line must stay high: no reply expected
    task automatic expect_quiet(output logic ok);
        ok = 1'b1;
        repeat (200) begin
            @(posedge sys_clk_i);
            if (line_i !== 1'b1) ok = 1'b0;
        end
    endtask : expect_quiet
endmodule : dci_host_model

/* verification/dci_top_tb.sv */
`timescale 1ns/1ps
module dci_top_tb;
    import dci_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        lock    = 1'b0;
    logic        enter   = 1'b0;
    logic [7:0]  status  = 8'h5a;
    logic [15:0] pc      = 16'hbeef;
    logic        host_line;
    wire         pin_o, oe_n, pc_wr, ctl_wr, halted, flash_only, ferr;
    wire [15:0]  pc_wdata, cntr;
    wire [7:0]   ctl;
    wire         line = host_line & (oe_n | pin_o);
    int          n_fail = 0;
    int          checks_done = 0;
    int          pc_wr_cnt = 0;
    int          ctl_wr_cnt = 0;
    int          ferr_cnt = 0;

    ////////////////////////////////////////////////////////////
    // Clock, and counting of program counter loads, control writes and frame errors
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (pc_wr === 1'b1) pc_wr_cnt++;
    always @(posedge sys_clk) if (ctl_wr === 1'b1) ctl_wr_cnt++;
    always @(posedge sys_clk) if (ferr === 1'b1) ferr_cnt++;

    dci_top dci_top_inst (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .debug_serial_pin_i(line),
        .debug_serial_pin_o(pin_o), .debug_serial_pin_oe_n_o(oe_n), .bit_cycles_i(10'h008),
        .read_lock_option_i(lock), .debug_enter_i(enter), .debugger_status_reg_i(status),
        .pc_i(pc), .pc_wr_o(pc_wr), .pc_wdata_o(pc_wdata), .ctl_wr_o(ctl_wr),
        .debugger_control_reg_o(ctl), .debug_down_counter_o(cntr),
        .halted_for_debug_flag_o(halted), .reg_write_flash_only_o(flash_only), .frame_error_o(ferr));
    dci_host_model #(.BIT_CYC(8)) dci_host_model_inst (.sys_clk_i(sys_clk), .line_i(line),
        .host_line_o(host_line));

    ////////////////////////////////////////////////////////////
    // Comparison, command helpers and verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] c, input int nb, input logic [15:0] exp);
        logic [7:0] hi, lo;
        logic       ok1, ok2;
        hi = 8'h00;
        ok1 = 1'b1;
        dci_host_model_inst.send_byte(c);
        if (nb == 2) dci_host_model_inst.recv_byte(hi, ok1);
        dci_host_model_inst.recv_byte(lo, ok2);
        chk({hi, lo}, exp);
        chk({14'h0000, ok1, ok2}, 16'h0003);
    endtask : rd

    task automatic wr(input logic [7:0] c, input int nb, input logic [15:0] v);
        dci_host_model_inst.send_byte(c);
        if (nb == 2) dci_host_model_inst.send_byte(v[15:8]);
        dci_host_model_inst.send_byte(v[7:0]);
        repeat (20) @(posedge sys_clk);
    endtask : wr

    task automatic quiet(input logic [7:0] c);
        logic ok;
        dci_host_model_inst.send_byte(c);
        dci_host_model_inst.expect_quiet(ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask : quiet

    task automatic tally_and_finish;
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic s_first_char;
        chk({8'h00, ctl}, {8'h00, CTL_RESET});
        quiet(8'h80);
    endtask : s_first_char

    task automatic s_halted;
        wr(CMD_CTL_WR, 1, 16'h0080);
        chk({15'h0000, halted}, 16'h0001);
        rd(CMD_CTL_RD, 1, 16'h0080);
        wr(CMD_CNTR_WR, 2, 16'h1234);
        chk(cntr, 16'h1234);
        rd(CMD_CNTR_RD, 2, 16'hedcb);
        wr(CMD_PC_WR, 2, 16'habcd);
        chk(pc_wdata, 16'habcd);
        chk(16'(pc_wr_cnt), 16'h0001);
        rd(CMD_PC_RD, 2, 16'hbeef);
        chk({15'h0000, flash_only}, 16'h0000);
    endtask : s_halted

    task automatic s_frame_err;
        dci_host_model_inst.send_byte(CMD_CNTR_WR);
        dci_host_model_inst.send_byte(8'h77);
        dci_host_model_inst.send_frame(8'h99, 1'b0);
        repeat (20) @(posedge sys_clk);
        chk(16'(ferr_cnt), 16'h0001);
        chk(cntr, 16'h1234);
        rd(CMD_CTL_RD, 1, 16'h0080);
    endtask : s_frame_err

    task automatic s_running;
        wr(CMD_CTL_WR, 1, 16'h0000);
        chk({15'h0000, halted}, 16'h0000);
        rd(CMD_REV_RD, 2, DEF_REVISION);
        rd(CMD_STAT_RD, 1, {8'h00, status});
        rd(CMD_CTL_RD, 1, 16'h0000);
        rd(CMD_CNTR_RD, 2, ALL_ONES16);
        rd(CMD_PC_RD, 2, ALL_ONES16);
        wr(CMD_CNTR_WR, 2, 16'h5555);
        chk(cntr, 16'h1234);
        wr(CMD_PC_WR, 2, 16'h1111);
        chk(16'(pc_wr_cnt), 16'h0001);
        enter <= 1'b1;
        @(posedge sys_clk);
        enter <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({15'h0000, halted}, 16'h0001);
        wr(CMD_CTL_WR, 1, 16'h0000);
        chk({15'h0000, halted}, 16'h0000);
    endtask : s_running

    task automatic s_locked;
        logic [7:0] rsv [3];
        rsv = '{8'h0f, 8'h13, 8'hff};
        wr(CMD_CTL_WR, 1, 16'h0080);
        lock <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({15'h0000, flash_only}, 16'h0001);
        rd(CMD_PC_RD, 2, ALL_ONES16);
        wr(CMD_PC_WR, 2, 16'h2222);
        chk(16'(pc_wr_cnt), 16'h0001);
        wr(CMD_CTL_WR, 1, 16'h0000);
        chk({8'h00, ctl}, 16'h0080);
        foreach (rsv[i]) quiet(rsv[i]);
        rd(CMD_STAT_RD, 1, {8'h00, status});
        chk(16'(ctl_wr_cnt), 16'h0005);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk({8'h00, ctl}, {8'h00, CTL_RESET});
        quiet(8'h80);
    endtask : s_locked

    ////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        s_first_char();
        s_halted();
        s_frame_err();
        s_running();
        s_locked();
        tally_and_finish();
    end

    initial begin
        repeat (50000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish();
    end
endmodule : dci_top_tb
